/* verilog/rwd_top.sv */
// reset and wakeup controller: user reset, pulse length, key, debouncers, backup clear
//
// How it works
// - reset pin low starts a user reset only while user reset enable is set
// - status flag raises the interrupt when irq enable set and reset enable clear
// - external reset driven for two to the power of length plus one slow ticks
// - mode writes need key 0xa5 in the top byte; key reads back zero
// - mode writes ignored while write protection is enabled
// - low-power event on an enabled, not clear-disabled pin clears backup half
// - force-wake must stay low for the selected slow-clock count
// - wake input must stay active for the selected slow-clock count
// - low-power period zero disables; one to seven need two to eight rtc periods
// - pin b feeds the low-power debouncer only when its enable is set
// - pin c feeds the low-power debouncer only when its enable is set
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "rwd_map.svh"
module rwd_top (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic external_reset_pin_in,
  output logic external_reset_pin_out,
  output logic external_reset_pin_oe,
  output logic user_reset,
  output logic reset_irq,
  input wire logic force_wake_input,
  input wire logic wake_inputs,
  input wire logic [3:0] wake_tamper_pins,
  input wire logic rtc_output_clock,
  output logic backup_clear,
  output logic system_wakeup
);
  // ****************************************************************
  // decode helpers
  // ****************************************************************
  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] SEL_STAT = 3'h1;
  localparam logic [2:0] SEL_MODE = 3'h2;
  localparam logic [2:0] SEL_WAKE = 3'h3;
  localparam logic [2:0] SEL_WP = 3'h4;
  // pin and force-wake idle high, so their synchronisers start high
  localparam logic [7:0] SYNC_RST = 8'h03;

  function automatic logic [2:0] reg_sel(input logic [31:0] addr);
    case (addr)
      `RWD_STAT_ADDR: reg_sel = SEL_STAT;
      `RWD_MODE_ADDR: reg_sel = SEL_MODE;
      `RWD_WAKE_ADDR: reg_sel = SEL_WAKE;
      `RWD_WP_ADDR: reg_sel = SEL_WP;
      default: reg_sel = SEL_NONE;
    endcase
  endfunction

  // reserved codes 6 and 7 fall back to the longest period
  function automatic logic [15:0] dbc_limit(input logic [2:0] code);
    case (code)
      3'h0: dbc_limit = `RWD_DBC_P0;
      3'h1: dbc_limit = `RWD_DBC_P1;
      3'h2: dbc_limit = `RWD_DBC_P2;
      3'h3: dbc_limit = `RWD_DBC_P3;
      3'h4: dbc_limit = `RWD_DBC_P4;
      default: dbc_limit = `RWD_DBC_P5;
    endcase
  endfunction

  rwd_pkg::rwd_top_st_t s_r;
  rwd_pkg::rwd_top_st_t s_nxt;
  logic [7:0] sync_in;
  logic [7:0] sync_out;
  logic pin_s;
  logic fw_evt;
  logic wk_evt;
  logic [3:0] lp_evt;
  logic [3:0] lp_act;
  logic [3:0] lp_conn;
  logic [3:0] lp_clr_ok;
  logic lp_on;
  logic [15:0] lp_limit;
  logic wr_do;
  logic [2:0] wr_sel;
  logic rd_do;
  logic [2:0] rd_sel;
  logic [16:0] ur_target;
  logic [31:0] mode_rd;
  logic [31:0] stat_rd;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  assign sync_in = {rtc_output_clock, wake_tamper_pins, wake_inputs, force_wake_input,
                    external_reset_pin_in};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_sync
      rwd_sync #(.RST_VAL(SYNC_RST[gi])) u_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .din(sync_in[gi]),
        .dout(sync_out[gi])
      );
    end
  endgenerate

  assign pin_s = sync_out[0];

  // ****************************************************************
  // debouncers
  // ****************************************************************
  rwd_debounce u_fw_dbc (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .tick(s_r.slow_tick),
    .active(!sync_out[1]),
    .limit(dbc_limit(s_r.wake_cfg[`RWD_FWDBC_MSB:`RWD_FWDBC_LSB])),
    .event_out(fw_evt)
  );

  rwd_debounce u_wk_dbc (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .tick(s_r.slow_tick),
    .active(sync_out[2]),
    .limit(dbc_limit(s_r.wake_cfg[`RWD_WKDBC_MSB:`RWD_WKDBC_LSB])),
    .event_out(wk_evt)
  );

  assign lp_on = (s_r.wake_cfg[`RWD_LP_PER_MSB:`RWD_LP_PER_LSB] != 3'h0);
  assign lp_limit = {13'h0000, s_r.wake_cfg[`RWD_LP_PER_MSB:`RWD_LP_PER_LSB]} + 16'h0001;
  assign lp_conn = {s_r.wake_cfg[`RWD_LPEN_C_BIT],
                    s_r.wake_cfg[`RWD_LPEN_B_BIT], 2'h3};
  assign lp_clr_ok = {~s_r.wake_cfg[`RWD_TCD_MSB:`RWD_TCD_LSB], 1'b1};

  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_lp
      assign lp_act[gi] = sync_out[3 + gi] & lp_conn[gi] & lp_on;
      rwd_debounce u_lp_dbc (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .tick(s_r.rtc_tick),
        .active(lp_act[gi]),
        .limit(lp_limit),
        .event_out(lp_evt[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // register bus and control state
  // ****************************************************************
  assign wr_do = s_r.aw_got && s_r.w_got && !s_r.bvalid;
  assign wr_sel = reg_sel(s_r.aw_addr);
  assign rd_do = s_axi_arvalid && !s_r.rvalid;
  assign rd_sel = reg_sel(s_axi_araddr);
  assign ur_target = 17'h00001 << ({1'b0, s_r.ur_len} + 5'h01);

  always_comb begin
    mode_rd = 32'h00000000; // key field always reads zero
    mode_rd[`RWD_UR_EN_BIT] = s_r.urst_en;
    mode_rd[`RWD_UR_IEN_BIT] = s_r.urst_ien;
    mode_rd[`RWD_RST_LEN_MSB:`RWD_RST_LEN_LSB] = s_r.rst_len;
    stat_rd = 32'h00000000;
    stat_rd[`RWD_ST_URST_BIT] = s_r.urst_flag;
    stat_rd[`RWD_ST_DRIVE_BIT] = (s_r.ur_state != rwd_pkg::UR_IDLE);
    stat_rd[`RWD_ST_FW_BIT] = s_r.fw_flag;
    stat_rd[`RWD_ST_WK_BIT] = s_r.wk_flag;
    stat_rd[`RWD_ST_LP_BIT] = s_r.lp_flag;
  end

  always_comb begin
    s_nxt = s_r;
    // write channels are taken independently, answered once both are held
    if (s_axi_awvalid && !s_r.aw_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_r.w_got && !s_r.bvalid) begin
      s_nxt.w_got = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (wr_do) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = (wr_sel == SEL_NONE) ? `RWD_RESP_SLVERR : `RWD_RESP_OKAY;
      case (wr_sel)
        SEL_MODE: begin
          // a bad key or protection aborts the whole word, not single fields
          if (!s_r.wp_on && s_r.w_strb[3] &&
              s_r.w_data[`RWD_KEY_MSB:`RWD_KEY_LSB] == `RWD_KEY_VAL) begin
            if (s_r.w_strb[0]) begin
              s_nxt.urst_en = s_r.w_data[`RWD_UR_EN_BIT];
              s_nxt.urst_ien = s_r.w_data[`RWD_UR_IEN_BIT];
            end
            if (s_r.w_strb[1]) begin
              s_nxt.rst_len = s_r.w_data[`RWD_RST_LEN_MSB:`RWD_RST_LEN_LSB];
            end
          end
        end
        SEL_WAKE: begin
          for (int b = 0; b < 4; b++) begin
            if (s_r.w_strb[b]) begin
              s_nxt.wake_cfg[b*8 +: 8] = s_r.w_data[b*8 +: 8];
            end
          end
          s_nxt.wake_cfg = s_nxt.wake_cfg & `RWD_WAKE_MASK;
        end
        SEL_WP: begin
          if (s_r.w_strb[0]) begin
            s_nxt.wp_on = s_r.w_data[`RWD_WP_ON_BIT];
          end
        end
        default: begin
        end
      endcase
    end
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (rd_do) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = (rd_sel == SEL_NONE) ? `RWD_RESP_SLVERR : `RWD_RESP_OKAY;
      case (rd_sel)
        SEL_STAT: begin
          s_nxt.rdata = stat_rd;
          // reading status clears the sticky flags; a set below still wins
          s_nxt.urst_flag = 1'b0;
          s_nxt.fw_flag = 1'b0;
          s_nxt.wk_flag = 1'b0;
          s_nxt.lp_flag = 1'b0;
        end
        SEL_MODE: s_nxt.rdata = mode_rd;
        SEL_WAKE: s_nxt.rdata = s_r.wake_cfg;
        SEL_WP: s_nxt.rdata = {31'h00000000, s_r.wp_on};
        default: s_nxt.rdata = 32'h00000000;
      endcase
    end
    // slow clock enable; the divider truncates, so the tick runs a little fast
    s_nxt.slow_tick = 1'b0;
    if (s_r.div_cnt == 11'(`RWD_SLOW_DIV - 1)) begin
      s_nxt.div_cnt = 11'h000;
      s_nxt.slow_tick = 1'b1;
    end else begin
      s_nxt.div_cnt = s_r.div_cnt + 11'h001;
    end
    s_nxt.rtc_prev = sync_out[7];
    s_nxt.rtc_tick = sync_out[7] & ~s_r.rtc_prev;
    // user reset sequence
    s_nxt.pin_prev = pin_s;
    case (s_r.ur_state)
      rwd_pkg::UR_IDLE: begin
        if (!pin_s && s_r.urst_en) begin
          s_nxt.ur_state = rwd_pkg::UR_DRIVE;
          s_nxt.ur_cnt = 17'h00000;
          s_nxt.ur_len = s_r.rst_len;
        end
        if (s_r.pin_prev && !pin_s) begin
          s_nxt.urst_flag = 1'b1;
        end
      end
      rwd_pkg::UR_DRIVE: begin
        if (s_r.slow_tick) begin
          if (s_r.ur_cnt + 17'h00001 == ur_target) begin
            s_nxt.ur_state = rwd_pkg::UR_RELEASE;
          end else begin
            s_nxt.ur_cnt = s_r.ur_cnt + 17'h00001;
          end
        end
      end
      rwd_pkg::UR_RELEASE: begin
        // our own drive held the pin low; wait for it to float back high
        if (pin_s) begin
          s_nxt.ur_state = rwd_pkg::UR_IDLE;
        end
      end
      default: s_nxt.ur_state = rwd_pkg::UR_IDLE;
    endcase
    if (fw_evt) begin
      s_nxt.fw_flag = 1'b1;
    end
    if (wk_evt) begin
      s_nxt.wk_flag = 1'b1;
    end
    if (|lp_evt) begin
      s_nxt.lp_flag = 1'b1;
    end
    s_nxt.bkp_clr = s_r.wake_cfg[`RWD_LPCLR_BIT] && |(lp_evt & lp_clr_ok);
    s_nxt.wake_req = fw_evt | wk_evt | (|lp_evt);
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '0;
      s_r.urst_en <= 1'(`RWD_MODE_RST >> `RWD_UR_EN_BIT);
      s_r.wake_cfg <= `RWD_WAKE_RST;
      s_r.wp_on <= `RWD_WP_RST;
      s_r.rtc_prev <= 1'b0;
      s_r.pin_prev <= 1'b1;
      s_r.ur_state <= rwd_pkg::UR_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
  assign s_axi_wready = !s_r.w_got && !s_r.bvalid;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign external_reset_pin_out = 1'b0;
  assign external_reset_pin_oe = (s_r.ur_state == rwd_pkg::UR_DRIVE);
  assign user_reset = (s_r.ur_state == rwd_pkg::UR_DRIVE);
  assign reset_irq = s_r.urst_flag && s_r.urst_ien && !s_r.urst_en;
  assign backup_clear = s_r.bkp_clr;
  assign system_wakeup = s_r.wake_req;

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [16:0] a_ticks;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      a_ticks <= 17'h00000;
    end else if (!external_reset_pin_oe) begin
      a_ticks <= 17'h00000;
    end else if (s_r.slow_tick) begin
      a_ticks <= a_ticks + 17'h00001;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_mode_wr;
    wr_do && wr_sel == SEL_MODE;
  endsequence

  sequence s_user_trig;
    s_r.ur_state == rwd_pkg::UR_IDLE && !pin_s;
  endsequence

  a_key_abort: assert property ((s_mode_wr and
      (s_r.w_data[`RWD_KEY_MSB:`RWD_KEY_LSB] != `RWD_KEY_VAL)) |=> $stable(mode_rd))
    else $error("mode changed by a write with a wrong key");
  a_key_reads_zero: assert property ((rd_do && rd_sel == SEL_MODE) |=>
      s_axi_rvalid && s_axi_rdata[`RWD_KEY_MSB:`RWD_KEY_LSB] == 8'h00)
    else $error("key field read back non-zero");
  a_wp_blocks: assert property ((s_mode_wr and s_r.wp_on) |=> $stable(mode_rd))
    else $error("mode changed while write protected");
  a_user_start: assert property ((s_user_trig and s_r.urst_en) |=> user_reset)
    else $error("user reset did not start on low pin");
  a_user_off: assert property ((s_user_trig and !s_r.urst_en) |=> !user_reset)
    else $error("user reset started while disabled");
  a_irq_gate: assert property (s_r.urst_en |-> !reset_irq)
    else $error("interrupt raised while user reset enabled");
  a_irq_rise: assert property ((s_r.urst_ien && !s_r.urst_en && $rose(s_r.urst_flag))
      |-> reset_irq)
    else $error("flag set but interrupt low");
  a_ext_length: assert property ($fell(external_reset_pin_oe) |-> a_ticks == ur_target)
    else $error("external reset length wrong");
  a_backup_clr: assert property ((s_r.wake_cfg[`RWD_LPCLR_BIT] &&
      |(lp_evt & lp_clr_ok)) |=> backup_clear)
    else $error("backup clear missing after low-power event");
  a_fw_cause: assert property (fw_evt |-> $past(!sync_out[1]) && $past(s_r.slow_tick))
    else $error("force-wake event without low input on a slow tick");
  a_wk_cause: assert property (wk_evt |-> $past(sync_out[2]) && $past(s_r.slow_tick))
    else $error("wake event without active input on a slow tick");
  a_lp_disabled: assert property (!lp_on [*2] |-> lp_evt == 4'h0)
    else $error("low-power event while disabled");
  a_pin_b_off: assert property (!lp_conn[2] [*2] |-> !lp_evt[2])
    else $error("pin b event while disconnected");
  a_pin_c_off: assert property (!lp_conn[3] [*2] |-> !lp_evt[3])
    else $error("pin c event while disconnected");
endmodule

/* pkg/rwd_map.svh */
// address map, field positions, reset values and timing counts of the reset/wake block
`ifndef RWD_MAP_SVH
`define RWD_MAP_SVH
`define RWD_STAT_ADDR 32'h400e1404
`define RWD_MODE_ADDR 32'h400e1408
`define RWD_WAKE_ADDR 32'h400e1410
`define RWD_WP_ADDR 32'h400e14e4
`define RWD_KEY_VAL 8'ha5
`define RWD_KEY_MSB 31
`define RWD_KEY_LSB 24
`define RWD_UR_EN_BIT 0
`define RWD_UR_IEN_BIT 4
`define RWD_RST_LEN_MSB 11
`define RWD_RST_LEN_LSB 8
`define RWD_FWDBC_MSB 2
`define RWD_FWDBC_LSB 0
`define RWD_WKDBC_MSB 14
`define RWD_WKDBC_LSB 12
`define RWD_LP_PER_MSB 18
`define RWD_LP_PER_LSB 16
`define RWD_LPEN_B_BIT 24
`define RWD_LPEN_C_BIT 25
`define RWD_TCD_MSB 29
`define RWD_TCD_LSB 27
`define RWD_LPCLR_BIT 30
`define RWD_WAKE_MASK 32'h7f077007
`define RWD_WP_ON_BIT 0
`define RWD_ST_URST_BIT 0
`define RWD_ST_DRIVE_BIT 8
`define RWD_ST_FW_BIT 16
`define RWD_ST_WK_BIT 17
`define RWD_ST_LP_BIT 18
`define RWD_MODE_RST 32'h00000000
`define RWD_WAKE_RST 32'h00000000
`define RWD_WP_RST 1'b0
`define RWD_CLK_HZ 50000000
`define RWD_SLOW_HZ 32768
`define RWD_SLOW_DIV (`RWD_CLK_HZ / `RWD_SLOW_HZ)
`define RWD_DBC_P0 16'h0001
`define RWD_DBC_P1 16'h0003
`define RWD_DBC_P2 16'h0020
`define RWD_DBC_P3 16'h0200
`define RWD_DBC_P4 16'h1000
`define RWD_DBC_P5 16'h8000
`define RWD_RESP_OKAY 2'h0
`define RWD_RESP_SLVERR 2'h2
`endif

/* pkg/rwd_pkg.sv */
// types shared by the reset/wake block modules
package rwd_pkg;
  typedef enum logic [1:0] {UR_IDLE, UR_DRIVE, UR_RELEASE} rwd_ur_t;
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } rwd_sync_st_t;
  typedef struct packed {
    logic [15:0] cnt;
    logic done;
    logic evt;
  } rwd_dbc_st_t;
  typedef struct packed {
    logic aw_got;
    logic [31:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic urst_en;
    logic urst_ien;
    logic [3:0] rst_len;
    logic [31:0] wake_cfg;
    logic wp_on;
    logic [10:0] div_cnt;
    logic slow_tick;
    logic rtc_prev;
    logic rtc_tick;
    logic pin_prev;
    logic urst_flag;
    logic fw_flag;
    logic wk_flag;
    logic lp_flag;
    rwd_ur_t ur_state;
    logic [16:0] ur_cnt;
    logic [3:0] ur_len;
    logic bkp_clr;
    logic wake_req;
  } rwd_top_st_t;
endpackage

/* verilog/rwd_sync.sv */
// three-stage input synchroniser that follows a change once stages two and three agree
`timescale 1ns/1ps
module rwd_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic din,
  output logic dout
);
  rwd_pkg::rwd_sync_st_t s_r;
  rwd_pkg::rwd_sync_st_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = din;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    if (s_r.s2 == s_r.s3) begin
      s_nxt.q = s_r.s3;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= {4{RST_VAL}};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dout = s_r.q;
endmodule

/* verilog/rwd_debounce.sv */
// period debouncer: one event after an unbroken run of active ticks
`timescale 1ns/1ps
module rwd_debounce (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic tick,
  input wire logic active,
  input wire logic [15:0] limit,
  output logic event_out
);
  rwd_pkg::rwd_dbc_st_t s_r;
  rwd_pkg::rwd_dbc_st_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.evt = 1'b0;
    if (!active) begin
      s_nxt.cnt = 16'h0000;
      s_nxt.done = 1'b0;
    end else if (tick && !s_r.done) begin
      if (({1'b0, s_r.cnt} + 17'h00001) >= {1'b0, limit}) begin
        s_nxt.evt = 1'b1;
        s_nxt.done = 1'b1;
        s_nxt.cnt = 16'h0000;
      end else begin
        s_nxt.cnt = s_r.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign event_out = s_r.evt;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_evt_has_cause: assert property (event_out |-> $past(active) && $past(tick))
    else $error("debounce event without an active tick");
  a_idle_no_evt: assert property (!active |=> !event_out)
    else $error("debounce event after inactive input");
endmodule

/* verification/rwd_pin_model.sv */
// pin-side partner: reset line with pull-up and a free-running rtc output clock
`timescale 1ns/1ps
module rwd_pin_model #(
  parameter int RTC_HALF_NS = 1000
) (
  input wire logic reset_oe,
  input wire logic pull_low,
  output logic pin_level,
  output logic rtc_clk
);
  // the rtc output runs free; it is not gated between events
  initial rtc_clk = 1'b0;
  always #(RTC_HALF_NS) rtc_clk = ~rtc_clk;
  // open drain: either party pulls low, otherwise the pull-up wins
  assign pin_level = (reset_oe || pull_low) ? 1'b0 : 1'b1;
endmodule

/* verification/rwd_top_tb.sv */
// self-checking bench for the reset and wakeup controller
`timescale 1ns/1ps
`include "rwd_map.svh"
module rwd_top_tb;
  logic clk_sys, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, pin_in, pin_out, pin_oe, user_reset;
  logic reset_irq, fwake, wake, rtc, bclr, wakeup, pull_low;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb, tpins;
  logic [1:0] bresp, rresp, wr_resp;
  int err_total = 0;
  int tests_run = 0;
  int n_clr = 0;
  int n_wake = 0;
  int n_rst = 0;

  rwd_pin_model i_rwd_pin_model (.reset_oe(pin_oe), .pull_low(pull_low), .pin_level(pin_in),
    .rtc_clk(rtc));
  rwd_top i_rwd_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .external_reset_pin_in(pin_in), .external_reset_pin_out(pin_out),
    .external_reset_pin_oe(pin_oe), .user_reset(user_reset), .reset_irq(reset_irq),
    .force_wake_input(fwake), .wake_inputs(wake), .wake_tamper_pins(tpins),
    .rtc_output_clock(rtc), .backup_clear(bclr), .system_wakeup(wakeup));

  always #10 clk_sys = ~clk_sys;

  // pulses are counted here so that a single-cycle event cannot slip past a check
  always @(posedge clk_sys) begin
    if (bclr === 1'b1) n_clr <= n_clr + 1;
    if (wakeup === 1'b1) n_wake <= n_wake + 1;
    if (user_reset === 1'b1) n_rst <= n_rst + 1;
  end

  // ****************************************
  // bus tasks and checks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // readies are looked at on the falling edge, where they are settled for the next rise
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
    logic ta, tw, gb;
    gb = 1'b0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!gb) begin
      @(negedge clk_sys);
      ta = awvalid && awready;
      tw = wvalid && wready;
      gb = bvalid;
      wr_resp = bresp;
      @(posedge clk_sys);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, gr;
    gr = 1'b0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!gr) begin
      @(negedge clk_sys);
      ta = arvalid && arready;
      gr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk_sys);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  // holds one pin pattern for n cycles, then returns it to idle
  task automatic hold_pins(input logic [3:0] p, input int n);
    tpins <= p;
    cyc(n);
    tpins <= 4'h0;
    cyc(10);
  endtask

  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    err_total++;
    print_verdict();
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int w0, c0, ticks;
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    {awaddr, wdata, araddr, wstrb, tpins} = '0;
    {awvalid, wvalid, bready, arvalid, rready, wake, pull_low} = '0;
    fwake = 1'b1;
    cyc(20);
    sys_rst <= 1'b0;
    axi_rd(`RWD_MODE_ADDR, d, r);
    chk("mode reset", `RWD_MODE_RST, d);
    axi_rd(`RWD_WAKE_ADDR, d, r);
    chk("wake cfg reset", `RWD_WAKE_RST, d);
    axi_rd(32'h400e1500, d, r);
    chk("unmapped resp", {30'h0, `RWD_RESP_SLVERR}, {30'h0, r});
    axi_wr(32'h400e1500, 32'hffffffff);
    chk("unmapped write resp", {30'h0, `RWD_RESP_SLVERR}, {30'h0, wr_resp});
    $display("test reset_values done");
    axi_wr(`RWD_MODE_ADDR, 32'h5a000011);
    chk("bad key resp", {30'h0, `RWD_RESP_OKAY}, {30'h0, wr_resp});
    axi_rd(`RWD_MODE_ADDR, d, r);
    chk("mode bad key", 32'h0, d);
    axi_wr(`RWD_MODE_ADDR, 32'ha5000010);
    axi_rd(`RWD_MODE_ADDR, d, r);
    chk("mode good key", 32'h00000010, d);
    axi_wr(`RWD_WP_ADDR, 32'h1);
    axi_wr(`RWD_MODE_ADDR, 32'ha5000011);
    axi_rd(`RWD_MODE_ADDR, d, r);
    chk("mode protected", 32'h00000010, d);
    axi_wr(`RWD_WP_ADDR, 32'h0);
    $display("test key_protect done");
    pull_low <= 1'b1;
    cyc(10);
    pull_low <= 1'b0;
    cyc(10);
    chk("irq disabled reset", 32'h1, {31'h0, reset_irq});
    chk("reset cycles disabled", 32'h0, n_rst);
    axi_rd(`RWD_STAT_ADDR, d, r);
    chk("status flag", 32'h1, d & 32'h1);
    axi_rd(`RWD_STAT_ADDR, d, r);
    cyc(2);
    chk("irq after clear", 32'h0, {31'h0, reset_irq});
    $display("test irq_no_reset done");
    axi_wr(`RWD_MODE_ADDR, 32'ha5000111);
    pull_low <= 1'b1;
    cyc(10);
    pull_low <= 1'b0;
    cyc(20);
    chk("user reset driven", 32'h1, {31'h0, user_reset});
    chk("reset pin drive", 32'h2, {30'h0, pin_oe, pin_out});
    chk("irq while enabled", 32'h0, {31'h0, reset_irq});
    cyc(7000);
    ticks = 2 ** (1 + 1);
    chk("reset length", 32'h1, {31'h0, n_rst >= (ticks - 1) * `RWD_SLOW_DIV &&
      n_rst <= ticks * `RWD_SLOW_DIV + 1});
    $display("test reset_length done");
    axi_wr(`RWD_WAKE_ADDR, 32'h0);
    w0 = n_wake;
    wake <= 1'b1;
    cyc(1600);
    wake <= 1'b0;
    cyc(10);
    chk("wake events", w0 + 1, n_wake);
    axi_rd(`RWD_STAT_ADDR, d, r);
    chk("wake status", 32'h00020000, d & 32'h00020000);
    axi_wr(`RWD_WAKE_ADDR, 32'h1);
    w0 = n_wake;
    repeat (2) begin
      fwake <= 1'b0;
      cyc(2 * `RWD_SLOW_DIV - 200);
      fwake <= 1'b1;
      cyc(10);
    end
    chk("force wake broken", w0, n_wake);
    fwake <= 1'b0;
    cyc(4 * `RWD_SLOW_DIV);
    fwake <= 1'b1;
    cyc(10);
    chk("force wake full", w0 + 1, n_wake);
    $display("test debounce done");
    axi_wr(`RWD_WAKE_ADDR, 32'h41010000);
    w0 = n_wake;
    c0 = n_clr;
    hold_pins(4'h8, 500);
    chk("pin c disabled", w0, n_wake);
    hold_pins(4'h4, 60);
    chk("pin b short", w0, n_wake);
    hold_pins(4'h4, 500);
    chk("pin b clear", c0 + 1, n_clr);
    chk("pin b wake", w0 + 1, n_wake);
    axi_wr(`RWD_WAKE_ADDR, 32'h51010000);
    hold_pins(4'h4, 500);
    chk("clear disabled", c0 + 1, n_clr);
    axi_wr(`RWD_WAKE_ADDR, 32'h41000000);
    hold_pins(4'h4, 500);
    chk("lp disabled", w0 + 2, n_wake);
    $display("test low_power done");
    print_verdict();
  end
endmodule
